/* sppol_map.svh */
// Constants of the sink power policy: thresholds, decode tables, timing.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef SPPOL_MAP_SVH
`define SPPOL_MAP_SVH
`define SPPOL_CLK_MHZ 125
`define SPPOL_BAND1_MV 12'h0F9
`define SPPOL_BAND2_MV 12'h313
`define SPPOL_BAND3_MV 12'h544
`define SPPOL_BAND4_MV 12'h781
`define SPPOL_BAND5_MV 12'h0ADB
`define SPPOL_V0_MV 15'h1388
`define SPPOL_V1_MV 15'h2328
`define SPPOL_V2_MV 15'h2EE0
`define SPPOL_V3_MV 15'h3A98
`define SPPOL_V4_MV 15'h4A38
`define SPPOL_V5_MV 15'h4E20
`define SPPOL_AMP_MA 13'h03E8
`define SPPOL_F1_MA 13'h00FA
`define SPPOL_F2_MA 13'h01F4
`define SPPOL_F3_MA 13'h02EE
`define SPPOL_F4_MA 13'h0384
`define SPPOL_LEG5_LO_MV 15'h128E
`define SPPOL_LEG5_HI_MV 15'h157C
`define SPPOL_DET_TIME_US 100
`define SPPOL_RECOVER_TIME_US 1000
`endif

/* sppol_pkg.sv */
// Types of the sink power policy: states, protocols and status bundles.
// Assumes sppol_map.svh for all numeric constants.
package sppol_pkg;
  typedef enum logic [2:0] {
    SPPOL_ST_IDLE = 3'b000,
    SPPOL_ST_DETECT = 3'b001,
    SPPOL_ST_PD = 3'b010,
    SPPOL_ST_LEGACY = 3'b011,
    SPPOL_ST_TYPEC = 3'b100,
    SPPOL_ST_RUN = 3'b101,
    SPPOL_ST_FAULT = 3'b110
  } sppol_state_t;
  typedef enum logic [2:0] {
    SPPOL_PR_NONE = 3'b000,
    SPPOL_PR_PD = 3'b001,
    SPPOL_PR_BC = 3'b010,
    SPPOL_PR_FC1 = 3'b011,
    SPPOL_PR_FC2 = 3'b100,
    SPPOL_PR_VND = 3'b101,
    SPPOL_PR_TYPEC = 3'b110
  } sppol_proto_t;
  // Status from the PD policy engine, same clock
  typedef struct packed {
    logic capable;
    logic done;
    logic ok;
    logic in_win;
    logic cur_ok;
    logic renego;
  } sppol_pd_t;
  // Status from the legacy line detectors, same clock
  typedef struct packed {
    logic bc;
    logic fc1;
    logic fc2;
    logic vnd;
    logic done;
    logic ok;
  } sppol_leg_t;
  // Analog protection comparators, asynchronous
  typedef struct packed {
    logic ovp;
    logic uvp;
    logic ocp;
    logic otp;
  } sppol_sense_t;
endpackage

/* sppol_top.sv */
// Sink power policy: decodes the four resistor settings, walks the
// protocol priority and drives main path, fallback path and fault.
// Assumes decoded ADC levels and protocol engines on i_clk; protection
// comparators and the legacy strap are asynchronous and synchronised here.
`include "sppol_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sppol_top
  import sppol_pkg::*;
#(
  parameter int DET_CYC = `SPPOL_DET_TIME_US * `SPPOL_CLK_MHZ,
  parameter int RECOVER_CYC = `SPPOL_RECOVER_TIME_US * `SPPOL_CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_min_voltage_setting,
  input wire logic [11:0] i_max_voltage_setting,
  input wire logic [11:0] i_coarse_current_setting,
  input wire logic [11:0] i_fine_current_setting,
  input wire logic i_attach,
  input wire sppol_pd_t i_pd,
  input wire sppol_leg_t i_leg,
  input wire sppol_sense_t i_sense,
  input wire logic i_otp_en,
  input wire logic i_fallback_dis,
  input wire logic i_legacy_dis,
  input wire logic i_legacy_sel,
  input wire logic i_host_cmd,
  input wire logic i_host_on,
  output logic o_main_path_gate_enable,
  output logic o_fallback_path_enable,
  output logic o_fault,
  output logic o_proto_reset,
  output logic o_detect_start,
  output logic o_legacy_start,
  output logic [2:0] o_protocol,
  output logic [14:0] o_win_lo_mv,
  output logic [14:0] o_win_hi_mv,
  output logic [12:0] o_requested_current_limit,
  output logic [14:0] o_leg_lo_mv,
  output logic [14:0] o_leg_hi_mv
);

  // Six-band level decode shared by all four settings
  function automatic logic [2:0] band(input logic [11:0] mv);
    logic [2:0] b;
    b = 3'h0;
    if (mv >= `SPPOL_BAND1_MV) b = 3'h1;
    if (mv >= `SPPOL_BAND2_MV) b = 3'h2;
    if (mv >= `SPPOL_BAND3_MV) b = 3'h3;
    if (mv >= `SPPOL_BAND4_MV) b = 3'h4;
    if (mv >= `SPPOL_BAND5_MV) b = 3'h5;
    return b;
  endfunction

  // Band to bus voltage in millivolts
  function automatic logic [14:0] volts(input logic [2:0] b);
    logic [14:0] v;
    case (b)
      3'h0: v = `SPPOL_V0_MV;
      3'h1: v = `SPPOL_V1_MV;
      3'h2: v = `SPPOL_V2_MV;
      3'h3: v = `SPPOL_V3_MV;
      3'h4: v = `SPPOL_V4_MV;
      default: v = `SPPOL_V5_MV;
    endcase
    return v;
  endfunction

  // Synchroniser stages for comparators and strap
  sppol_sense_t sense_m_r; // First stage, read only by second
  sppol_sense_t sense_r; // Safe copy
  logic strap_m_r; // First stage of strap
  logic strap_s_r; // Safe copy of strap
  logic [1:0] strap_cnt_r; // Edges since reset release, saturates at three
  logic bc_only_r; // Captured strap: BC1.2 only

  // Decoded settings
  logic [2:0] min_b; // Minimum voltage band
  logic [2:0] max_b; // Maximum voltage band
  logic [2:0] win_lo_b; // Effective lower band
  logic [2:0] fine_b; // Fine band, capped at four
  logic [12:0] cur_ma; // Requested operating current
  logic min5; // System accepts 5 V input
  logic both5; // Both bounds at 5 V
  logic vbus_bad; // Bus out of range
  logic sense_fault; // Any enabled protection trip

  // Policy state
  sppol_state_t state_r, state_nxt;
  sppol_proto_t proto_r, proto_nxt;
  logic [19:0] timer_r, timer_nxt; // Detect and recovery timer
  logic pol_main_r, pol_main_nxt; // Policy wants main path
  logic pol_fb_r, pol_fb_nxt; // Policy wants fallback path
  logic fault_r, fault_nxt; // Fault indicator level
  logic host_ovr_r, host_ovr_nxt; // Host override active
  logic host_on_r, host_on_nxt; // Host requested level
  logic main_r, main_nxt; // Main gate output
  logic fb_r, fb_nxt; // Fallback gate output
  logic preset_r, preset_nxt; // Protocol reset pulse
  logic dstart_r, dstart_nxt; // Detect start pulse
  logic lstart_r, lstart_nxt; // Legacy start pulse

  // Settings decode, combinational from same-clock ADC words
  always_comb begin
    min_b = band(i_min_voltage_setting);
    max_b = band(i_max_voltage_setting);
    win_lo_b = (min_b > max_b) ? max_b : min_b;
    fine_b = band(i_fine_current_setting);
    if (fine_b > 3'h4) begin
      fine_b = 3'h4; // Top fine offset from the fourth band up
    end
    cur_ma = 13'(band(i_coarse_current_setting) * `SPPOL_AMP_MA);
    case (fine_b)
      3'h1: cur_ma = cur_ma + `SPPOL_F1_MA;
      3'h2: cur_ma = cur_ma + `SPPOL_F2_MA;
      3'h3: cur_ma = cur_ma + `SPPOL_F3_MA;
      3'h4: cur_ma = cur_ma + `SPPOL_F4_MA;
      default: cur_ma = cur_ma;
    endcase
    min5 = (win_lo_b == 3'h0);
    both5 = min5 && (max_b == 3'h0);
    vbus_bad = sense_r.ovp || sense_r.uvp;
    sense_fault = vbus_bad || sense_r.ocp || (i_otp_en && sense_r.otp);
  end

  // Two-flop synchronisers; strap is caught once after reset release
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sense_m_r <= '0;
      sense_r <= '0;
      strap_m_r <= 1'b0;
      strap_s_r <= 1'b0;
      strap_cnt_r <= 2'h0;
      bc_only_r <= 1'b0;
    end else begin
      sense_m_r <= i_sense;
      sense_r <= sense_m_r;
      strap_m_r <= i_legacy_sel;
      strap_s_r <= strap_m_r;
      if (strap_cnt_r != 2'h3) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      // Wait until the pin has passed both stages, not their reset value
      if (strap_cnt_r == 2'h2) begin
        bc_only_r <= strap_s_r; // High strap means BC1.2 only
      end
    end
  end

  // Policy sequencer: protocol choice, outcome, fault and path intent
  always_comb begin
    state_nxt = state_r;
    proto_nxt = proto_r;
    timer_nxt = timer_r;
    pol_main_nxt = pol_main_r;
    pol_fb_nxt = pol_fb_r;
    fault_nxt = fault_r;
    host_ovr_nxt = host_ovr_r;
    host_on_nxt = host_on_r;
    preset_nxt = 1'b0;
    dstart_nxt = 1'b0;
    lstart_nxt = 1'b0;
    // Host commands are taken in every state, renegotiation included
    if (i_host_cmd) begin
      host_ovr_nxt = 1'b1;
      host_on_nxt = i_host_on;
    end
    case (state_r)
      SPPOL_ST_IDLE: begin
        pol_main_nxt = 1'b0;
        pol_fb_nxt = 1'b0;
        proto_nxt = SPPOL_PR_NONE;
        if (i_attach) begin
          dstart_nxt = 1'b1; // PD and BC1.2 detection start together
          timer_nxt = 20'(DET_CYC);
          state_nxt = SPPOL_ST_DETECT;
        end
      end
      SPPOL_ST_DETECT: begin
        if (i_pd.capable) begin
          proto_nxt = SPPOL_PR_PD; // PD takes precedence
          state_nxt = SPPOL_ST_PD;
        end else if (timer_r != 20'h0_0000) begin
          timer_nxt = timer_r - 20'h0_0001;
        end else if (i_legacy_dis) begin
          proto_nxt = SPPOL_PR_TYPEC;
          state_nxt = SPPOL_ST_TYPEC;
        end else begin
          // Fixed priority walk; strap masks all but BC1.2
          state_nxt = SPPOL_ST_LEGACY;
          lstart_nxt = 1'b1;
          if (i_leg.bc) begin
            proto_nxt = SPPOL_PR_BC;
          end else if (i_leg.fc1 && !bc_only_r) begin
            proto_nxt = SPPOL_PR_FC1;
          end else if (i_leg.fc2 && !bc_only_r) begin
            proto_nxt = SPPOL_PR_FC2;
          end else if (i_leg.vnd && !bc_only_r) begin
            proto_nxt = SPPOL_PR_VND;
          end else begin
            proto_nxt = SPPOL_PR_TYPEC;
            lstart_nxt = 1'b0;
            state_nxt = SPPOL_ST_TYPEC;
          end
        end
      end
      SPPOL_ST_PD: begin
        // Fault level frozen until the contract can be judged
        if (i_pd.done) begin
          state_nxt = SPPOL_ST_RUN;
          if (i_pd.ok && i_pd.in_win && i_pd.cur_ok) begin
            pol_main_nxt = 1'b1;
            pol_fb_nxt = 1'b0;
            fault_nxt = 1'b0;
          end else if (i_pd.ok) begin
            pol_main_nxt = 1'b0;
            pol_fb_nxt = 1'b1; // Contract fell back to 5 V
            fault_nxt = 1'b1;
          end else begin
            pol_main_nxt = min5;
            pol_fb_nxt = 1'b0;
            fault_nxt = !min5;
          end
        end
      end
      SPPOL_ST_LEGACY: begin
        if (i_leg.done) begin
          state_nxt = SPPOL_ST_RUN;
          pol_main_nxt = i_leg.ok;
          pol_fb_nxt = !i_leg.ok; // 5 V contract with fallback
          fault_nxt = !i_leg.ok && !min5;
        end
      end
      SPPOL_ST_TYPEC: begin
        // Plain Type-C current gives 5 V only
        state_nxt = SPPOL_ST_RUN;
        pol_main_nxt = min5;
        pol_fb_nxt = !min5;
        fault_nxt = !min5;
      end
      SPPOL_ST_RUN: begin
        if (i_pd.renego && (proto_r == SPPOL_PR_PD)) begin
          state_nxt = SPPOL_ST_PD; // Paths and fault hold meanwhile
        end
      end
      SPPOL_ST_FAULT: begin
        if (timer_r != 20'h0_0000) begin
          timer_nxt = timer_r - 20'h0_0001;
        end else begin
          state_nxt = SPPOL_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SPPOL_ST_IDLE;
      end
    endcase
    // Protection trip overrides every state except idle and recovery itself
    if (sense_fault && (state_r != SPPOL_ST_FAULT) && (state_r != SPPOL_ST_IDLE)) begin
      fault_nxt = 1'b1;
      pol_main_nxt = 1'b0; // Output power removed
      pol_fb_nxt = 1'b0;
      preset_nxt = 1'b1; // Protocol reset to recover
      timer_nxt = 20'(RECOVER_CYC);
      state_nxt = SPPOL_ST_FAULT;
      host_ovr_nxt = 1'b0;
    end
    // Detach returns to idle and drops any host override
    if (!i_attach) begin
      state_nxt = SPPOL_ST_IDLE;
      pol_main_nxt = 1'b0;
      pol_fb_nxt = 1'b0;
      host_ovr_nxt = 1'b0;
      fault_nxt = (state_r == SPPOL_ST_FAULT) ? fault_r : 1'b0;
    end
    // Final gates: bus range wins on main, overvoltage only on fallback, then host, then policy
    if (host_ovr_nxt) begin
      main_nxt = host_on_nxt && !vbus_bad;
    end else begin
      main_nxt = pol_main_nxt && !vbus_bad;
    end
    fb_nxt = pol_fb_nxt && !min5 && !sense_r.ovp && !i_fallback_dis
      && !main_nxt;
  end

  // Sequencer and output registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= SPPOL_ST_IDLE;
      proto_r <= SPPOL_PR_NONE;
      timer_r <= 20'h0_0000;
      pol_main_r <= 1'b0;
      pol_fb_r <= 1'b0;
      fault_r <= 1'b0; // Low by default
      host_ovr_r <= 1'b0;
      host_on_r <= 1'b0;
      main_r <= 1'b0;
      fb_r <= 1'b0;
      preset_r <= 1'b0;
      dstart_r <= 1'b0;
      lstart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      proto_r <= proto_nxt;
      timer_r <= timer_nxt;
      pol_main_r <= pol_main_nxt;
      pol_fb_r <= pol_fb_nxt;
      fault_r <= fault_nxt;
      host_ovr_r <= host_ovr_nxt;
      host_on_r <= host_on_nxt;
      main_r <= main_nxt;
      fb_r <= fb_nxt;
      preset_r <= preset_nxt;
      dstart_r <= dstart_nxt;
      lstart_r <= lstart_nxt;
    end
  end

  // Registered decode results for the protocol engines
  logic [14:0] win_lo_r, win_hi_r, leg_lo_r, leg_hi_r;
  logic [12:0] cur_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      win_lo_r <= `SPPOL_V0_MV;
      win_hi_r <= `SPPOL_V0_MV;
      leg_lo_r <= `SPPOL_LEG5_LO_MV;
      leg_hi_r <= `SPPOL_LEG5_HI_MV;
      cur_r <= 13'h0000;
    end else begin
      win_lo_r <= volts(win_lo_b);
      win_hi_r <= volts(max_b);
      leg_lo_r <= both5 ? `SPPOL_LEG5_LO_MV : volts(win_lo_b);
      leg_hi_r <= both5 ? `SPPOL_LEG5_HI_MV : volts(max_b);
      cur_r <= cur_ma;
    end
  end

  assign o_main_path_gate_enable = main_r;
  assign o_fallback_path_enable = fb_r;
  assign o_fault = fault_r;
  assign o_proto_reset = preset_r;
  assign o_detect_start = dstart_r;
  assign o_legacy_start = lstart_r;
  assign o_protocol = proto_r;
  assign o_win_lo_mv = win_lo_r;
  assign o_win_hi_mv = win_hi_r;
  assign o_requested_current_limit = cur_r;
  assign o_leg_lo_mv = leg_lo_r;
  assign o_leg_hi_mv = leg_hi_r;

endmodule
`default_nettype wire

/* sppol_adapter.sv */
// Behavioural Type-C power adapter facing the sink power policy.
// Assumes the policy's start pulses and the bench's offer settings on i_clk.
`timescale 1ns/100ps
`default_nettype none
module sppol_adapter
  import sppol_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_attach,
  input wire logic i_detect_start,
  input wire logic i_legacy_start,
  input wire logic i_renego_req,
  input wire logic i_slow,
  input wire sppol_pd_t i_cfg_pd,
  input wire sppol_leg_t i_cfg_leg,
  output var sppol_pd_t o_pd,
  output var sppol_leg_t o_leg
);
  logic [5:0] pd_cnt_r, leg_cnt_r, dly;
  // Answer delay: prompt, or slow enough to show the held outputs
  assign dly = i_slow ? 6'h28 : 6'h03;
  // Outcome lines carry the inverse result outside the done pulse, so a
  // policy that samples them early reads the wrong answer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pd <= '0;
      o_leg <= '0;
      pd_cnt_r <= '0;
      leg_cnt_r <= '0;
    end else begin
      o_pd.capable <= i_attach & i_cfg_pd.capable;
      o_pd.renego <= i_renego_req;
      o_pd.done <= pd_cnt_r == 6'h01;
      o_pd[3:1] <= pd_cnt_r == 6'h01 ? i_cfg_pd[3:1] : ~i_cfg_pd[3:1];
      o_leg[5:2] <= i_attach ? i_cfg_leg[5:2] : 4'h0;
      o_leg.done <= leg_cnt_r == 6'h01;
      o_leg.ok <= leg_cnt_r == 6'h01 ? i_cfg_leg.ok : ~i_cfg_leg.ok;
      // A contract is answered only when PD was offered or renegotiated
      if (i_renego_req || (i_detect_start && i_cfg_pd.capable)) pd_cnt_r <= dly;
      else if (pd_cnt_r != 6'h00) pd_cnt_r <= pd_cnt_r - 6'h01;
      if (i_legacy_start) leg_cnt_r <= dly;
      else if (leg_cnt_r != 6'h00) leg_cnt_r <= leg_cnt_r - 6'h01;
    end
  end
endmodule
`default_nettype wire

/* sppol_top_chk.sv */
// Checker for the sink power policy: gates, fault entry, host and decode.
// Assumes sppol_pkg is compiled first; bound to sppol_top below.
`include "sppol_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sppol_top_chk
  import sppol_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_attach,
  input wire sppol_pd_t i_pd,
  input wire sppol_sense_t i_sense,
  input wire logic i_fallback_dis,
  input wire logic i_host_cmd,
  input wire logic i_host_on,
  input wire logic o_main_path_gate_enable,
  input wire logic o_fallback_path_enable,
  input wire logic o_fault,
  input wire logic o_proto_reset,
  input wire logic [2:0] o_protocol,
  input wire logic [14:0] o_win_lo_mv,
  input wire logic [14:0] o_win_hi_mv,
  input wire logic [14:0] o_leg_lo_mv,
  input wire logic [14:0] o_leg_hi_mv
);
  // One clock domain, so clocking and disable are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Good PD answer while already in the PD protocol
  sequence s_pd_good;
    i_pd.done && i_pd.ok && i_pd.in_win && i_pd.cur_ok && o_protocol == SPPOL_PR_PD;
  endsequence
  // Bus leaves range and stays out long enough to pass the synchroniser
  sequence s_bus_bad;
    $rose(i_sense.ovp || i_sense.uvp) ##1 (i_sense.ovp || i_sense.uvp) [*2];
  endsequence
  property p_excl;
    !(o_main_path_gate_enable && o_fallback_path_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("main and fallback both on");
  property p_pd_good;
    s_pd_good ##0 (i_sense == 4'h0) |=> o_main_path_gate_enable && !o_fault;
  endproperty
  a_pd_good: assert property (p_pd_good) else $error("good contract not taken");
  property p_bus_bad;
    s_bus_bad |=> !o_main_path_gate_enable;
  endproperty
  a_bus_bad: assert property (p_bus_bad) else $error("main kept on bad bus");
  property p_rst_pulse;
    o_proto_reset |=> !o_proto_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("protocol reset too long");
  property p_fault_entry;
    o_proto_reset |-> o_fault && !o_main_path_gate_enable && !o_fallback_path_enable;
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("power kept in fault");
  property p_ocp;
    (i_attach && i_sense.ocp) [*6] |-> o_fault;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not flagged");
  property p_host_off;
    i_host_cmd && !i_host_on |=> !o_main_path_gate_enable;
  endproperty
  a_host_off: assert property (p_host_off) else $error("host off ignored");
  property p_fb_dis;
    i_fallback_dis [*2] |-> !o_fallback_path_enable;
  endproperty
  a_fb_dis: assert property (p_fb_dis) else $error("fallback on while disabled");
  property p_win;
    o_win_lo_mv <= o_win_hi_mv;
  endproperty
  a_win: assert property (p_win) else $error("window lower above upper");
  property p_leg5;
    o_win_hi_mv == `SPPOL_V0_MV |->
      o_leg_lo_mv == `SPPOL_LEG5_LO_MV && o_leg_hi_mv == `SPPOL_LEG5_HI_MV;
  endproperty
  a_leg5: assert property (p_leg5) else $error("legacy 5 V window wrong");
  property p_hold;
    o_protocol == SPPOL_PR_PD && i_attach && !i_pd.done && i_sense == 4'h0 &&
      $past(i_sense) == 4'h0 && $past(i_sense, 2) == 4'h0 |=> $stable(o_fault);
  endproperty
  a_hold: assert property (p_hold) else $error("fault moved during contract");
endmodule
bind sppol_top sppol_top_chk chk_u (
  .i_clk, .i_rst_b, .i_attach, .i_pd, .i_sense, .i_fallback_dis, .i_host_cmd, .i_host_on,
  .o_main_path_gate_enable, .o_fallback_path_enable, .o_fault, .o_proto_reset,
  .o_protocol, .o_win_lo_mv, .o_win_hi_mv, .o_leg_lo_mv, .o_leg_hi_mv
);
`default_nettype wire

/* sppol_top_bench.sv */
// Self-checking bench for the sink power policy with an adapter model.
// Assumes design, adapter model and checker are compiled before it.
`include "sppol_map.svh"
`timescale 1ns/100ps
`default_nettype none
module sppol_top_bench;
  import sppol_pkg::*;
  logic i_clk, i_rst_b, i_attach, i_otp_en, i_fallback_dis, i_legacy_dis;
  logic i_legacy_sel, i_host_cmd, i_host_on, renego_req, slow;
  logic [11:0] i_min_voltage_setting, i_max_voltage_setting;
  logic [11:0] i_coarse_current_setting, i_fine_current_setting;
  sppol_pd_t i_pd, cfg_pd;
  sppol_leg_t i_leg, cfg_leg;
  sppol_sense_t i_sense;
  logic o_main_path_gate_enable, o_fallback_path_enable, o_fault, o_proto_reset;
  logic o_detect_start, o_legacy_start;
  logic [2:0] o_protocol;
  logic [12:0] o_requested_current_limit;
  logic [14:0] o_win_lo_mv, o_win_hi_mv, o_leg_lo_mv, o_leg_hi_mv;
  int num_errors, checks;
  // Both edges of each band in mV, and what each band decodes to
  logic [11:0] edges [12] = '{12'h000, 12'h0F8, 12'h0F9, 12'h312, 12'h313, 12'h543,
    12'h544, 12'h780, 12'h781, 12'hADA, 12'hADB, 12'hFFF};
  logic [14:0] volts [6] = '{`SPPOL_V0_MV, `SPPOL_V1_MV, `SPPOL_V2_MV, `SPPOL_V3_MV,
    `SPPOL_V4_MV, `SPPOL_V5_MV};
  logic [12:0] fines [6] = '{13'h0000, `SPPOL_F1_MA, `SPPOL_F2_MA, `SPPOL_F3_MA,
    `SPPOL_F4_MA, `SPPOL_F4_MA};
  // Short detect and recovery counts keep the run brief
  sppol_top #(.DET_CYC(20), .RECOVER_CYC(20)) dut_u (
    .i_clk, .i_rst_b, .i_min_voltage_setting, .i_max_voltage_setting,
    .i_coarse_current_setting, .i_fine_current_setting, .i_attach, .i_pd, .i_leg,
    .i_sense, .i_otp_en, .i_fallback_dis, .i_legacy_dis, .i_legacy_sel, .i_host_cmd,
    .i_host_on, .o_main_path_gate_enable, .o_fallback_path_enable, .o_fault,
    .o_proto_reset, .o_detect_start, .o_legacy_start, .o_protocol, .o_win_lo_mv,
    .o_win_hi_mv, .o_requested_current_limit, .o_leg_lo_mv, .o_leg_hi_mv
  );
  sppol_adapter ad_u (
    .i_clk, .i_rst_b, .i_attach, .i_detect_start(o_detect_start),
    .i_legacy_start(o_legacy_start), .i_renego_req(renego_req), .i_slow(slow),
    .i_cfg_pd(cfg_pd), .i_cfg_leg(cfg_leg), .o_pd(i_pd), .o_leg(i_leg)
  );
  always #4 i_clk = ~i_clk;
  task automatic complete_run;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs move only at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic do_reset;
    i_rst_b = 1'b0;
    cyc(3);
    i_rst_b = 1'b1;
    cyc(4);
  endtask
  task automatic settle(input logic [11:0] vmin, vmax, coarse, fine);
    i_min_voltage_setting = vmin;
    i_max_voltage_setting = vmax;
    i_coarse_current_setting = coarse;
    i_fine_current_setting = fine;
    cyc(2);
  endtask
  // Attach, wait for the expected protocol, then let the outcome land
  task automatic attach_wait(input logic [2:0] pr);
    int n;
    i_attach = 1'b1;
    for (n = 0; n < 200 && o_protocol !== pr; n++) cyc(1);
    if (n == 200) begin
      num_errors++;
      complete_run();
    end
    cyc(6);
  endtask
  task automatic detach(input int n);
    i_attach = 1'b0;
    cyc(n);
  endtask
  task automatic outs(input logic [2:0] pr, input logic m, input logic fb, input logic ft);
    chk("protocol", 15'(o_protocol), 15'(pr));
    chk("main", 15'(o_main_path_gate_enable), 15'(m));
    chk("fallback", 15'(o_fallback_path_enable), 15'(fb));
    chk("fault", 15'(o_fault), 15'(ft));
  endtask
  initial begin
    int n;
    i_clk = 1'b0;
    {i_rst_b, i_attach, i_otp_en, i_fallback_dis, i_legacy_dis, i_legacy_sel} = 6'h00;
    {i_host_cmd, i_host_on, renego_req, slow} = 4'h0;
    i_sense = 4'h0;
    cfg_pd = 6'h2E;
    cfg_leg = 6'h21;
    num_errors = 0;
    checks = 0;
    settle(12'h000, 12'h000, 12'h000, 12'h000);
    do_reset();
    chk("leg_lo", o_leg_lo_mv, `SPPOL_LEG5_LO_MV);
    chk("leg_hi", o_leg_hi_mv, `SPPOL_LEG5_HI_MV);
    for (int k = 0; k < 12; k++) begin
      settle(edges[k], edges[k], edges[k], edges[k]);
      chk("win_hi", o_win_hi_mv, volts[k / 2]);
      chk("win_lo", o_win_lo_mv, volts[k / 2]);
      chk("cur", 15'(o_requested_current_limit), 15'(k / 2 * 1000 + fines[k / 2]));
    end
    settle(12'hADB, 12'h3E8, 12'h313, 12'h000);
    chk("win_lo", o_win_lo_mv, `SPPOL_V2_MV);
    chk("win_hi", o_win_hi_mv, `SPPOL_V2_MV);
    chk("leg_lo", o_leg_lo_mv, `SPPOL_V2_MV);
    chk("leg_hi", o_leg_hi_mv, `SPPOL_V2_MV);
    // PD wins over BC1.2, then renegotiates slowly into a window miss
    settle(12'h1F4, 12'hFFF, 12'h313, 12'h000);
    attach_wait(SPPOL_PR_PD);
    outs(SPPOL_PR_PD, 1'b1, 1'b0, 1'b0);
    cfg_pd = 6'h2A;
    slow = 1'b1;
    renego_req = 1'b1;
    cyc(1);
    renego_req = 1'b0;
    cyc(20);
    outs(SPPOL_PR_PD, 1'b1, 1'b0, 1'b0);
    cyc(30);
    outs(SPPOL_PR_PD, 1'b0, 1'b1, 1'b1);
    // Host turns the main path on, then off again
    {i_host_cmd, i_host_on} = 2'h3;
    cyc(1);
    i_host_cmd = 1'b0;
    cyc(1);
    outs(SPPOL_PR_PD, 1'b1, 1'b0, 1'b1);
    {i_host_cmd, i_host_on} = 2'h2;
    cyc(1);
    i_host_cmd = 1'b0;
    cyc(1);
    chk("main", 15'(o_main_path_gate_enable), 15'h0000);
    // Overcurrent: fault, power removed, protocol reset
    i_sense = 4'h2;
    for (n = 0; n < 10 && o_proto_reset !== 1'b1; n++) cyc(1);
    chk("proto_reset", 15'(o_proto_reset), 15'h0001);
    chk("fault", 15'(o_fault), 15'h0001);
    chk("main", 15'(o_main_path_gate_enable), 15'h0000);
    cyc(6);
    i_sense = 4'h0;
    detach(30);
    // PD fails while the minimum is above 5 V
    cfg_pd = 6'h26;
    slow = 1'b0;
    attach_wait(SPPOL_PR_PD);
    chk("fault", 15'(o_fault), 15'h0001);
    chk("main", 15'(o_main_path_gate_enable), 15'h0000);
    detach(30);
    // No PD: legacy pick, then the strap limits it to BC1.2
    cfg_pd = 6'h00;
    cfg_leg = 6'h19;
    attach_wait(SPPOL_PR_FC1);
    outs(SPPOL_PR_FC1, 1'b1, 1'b0, 1'b0);
    detach(5);
    i_legacy_sel = 1'b1;
    do_reset();
    attach_wait(SPPOL_PR_TYPEC);
    outs(SPPOL_PR_TYPEC, 1'b0, 1'b1, 1'b1);
    detach(5);
    cfg_leg = 6'h20;
    attach_wait(SPPOL_PR_BC);
    outs(SPPOL_PR_BC, 1'b0, 1'b1, 1'b1);
    detach(5);
    // Legacy off with a 5 V minimum, then overvoltage
    i_legacy_dis = 1'b1;
    settle(12'h000, 12'h000, 12'h313, 12'h000);
    attach_wait(SPPOL_PR_TYPEC);
    outs(SPPOL_PR_TYPEC, 1'b1, 1'b0, 1'b0);
    i_sense = 4'h8;
    cyc(4);
    chk("main", 15'(o_main_path_gate_enable), 15'h0000);
    i_sense = 4'h0;
    detach(30);
    i_fallback_dis = 1'b1;
    settle(12'h1F4, 12'hFFF, 12'h313, 12'h000);
    attach_wait(SPPOL_PR_TYPEC);
    outs(SPPOL_PR_TYPEC, 1'b0, 1'b0, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
